// *** rtl/gpio_pkg.sv ***
/*
 * Constants and types shared by the pin control unit and its pwm generator.
 * Assumes a 10 MHz core clock and a separate link clock with no phase relation to it.
 */
package gpio_pkg;
	localparam int NUM_PINS = 6;
	localparam logic [2:0] FIRST_SEL = 3'h1;
	localparam logic [2:0] LAST_SEL = 3'h6;
	localparam logic [2:0] FIRST_PWM_SEL = 3'h3;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PWM_TICK_NS = 1000;
	localparam int PWM_TICK_CYCLES = (PWM_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 4;
	localparam int RSP_W = 18;
	localparam int SETUP_PERIOD_LSB = 0;
	localparam int SETUP_RATIO_LSB = 8;
	localparam int SETUP_FUNC_LSB = 16;
	localparam logic [7:0] DEF_RATIO = 8'h00;
	localparam logic [7:0] DEF_PERIOD = 8'h01;

	typedef enum logic [1:0] {
		FN_NONE = 2'b00,
		FN_INPUT = 2'b01,
		FN_OUTPUT = 2'b10,
		FN_PWM = 2'b11
	} pin_func_t;

	typedef enum logic [2:0] {
		OP_SETUP = 3'b000,
		OP_READ_SETUP = 3'b001,
		OP_WRITE = 3'b010,
		OP_READ = 3'b011,
		OP_DEFAULTS = 3'b100
	} cmd_op_t;

	typedef enum logic {
		STAT_OK = 1'b0,
		STAT_REJECT = 1'b1
	} status_t;

	localparam pin_func_t DEF_FUNC = FN_NONE;
endpackage

// *** rtl/pin_pwm.sv ***
/*
 * Pwm generator for one pin: counts ticks over the period, high for ratio/256 of it.
 * Assumes tick_in is a one-cycle pulse from the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_pwm (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// setup
	input wire logic tick_in,
	input wire logic [7:0] ratio_in,
	input wire logic [7:0] period_in,
	// wave
	output logic pwm_out
);
	import gpio_pkg::*;

	logic [7:0] cnt_r;
	logic [15:0] on_ticks;
	logic [15:0] pos_scaled;

	assign on_ticks = 16'(ratio_in) * 16'(period_in);
	assign pos_scaled = {cnt_r, 8'h00};

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cnt_r <= 8'h00;
		end else if (tick_in) begin
			if (cnt_r + 8'h01 >= period_in) begin
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

	// compare scaled position against ratio*period so 0x40 lands exactly on a quarter
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pwm_out <= 1'b0;
		end else begin
			pwm_out <= (period_in != 8'h00) && (pos_scaled < on_ticks);
		end
	end

	// a shorter period only takes hold at the next tick, so the wrap is checked right after a tick
	a_pwm_period_wrap: assert property (@(posedge clk_in) disable iff (!rstn_in)
		tick_in && (period_in != 8'h00) |=> cnt_r < $past(period_in))
		else $error("pwm count beyond period");
endmodule
`default_nettype wire

// *** rtl/pin_control.sv ***
/*
 * Pin control unit: host command port on clk_in, remote command port on link_clk_in,
 * persistent pin setup, output levels, pwm pins and write notices to each side.
 * Assumes host commands come from logic on clk_in and link signals from logic on link_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_control (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// host commands
	input wire logic host_valid_in,
	output logic host_ready_out,
	input wire gpio_pkg::cmd_op_t host_op_in,
	input wire logic [2:0] host_sel_in,
	input wire gpio_pkg::pin_func_t host_func_in,
	input wire logic host_value_in,
	input wire logic [7:0] host_ratio_in,
	input wire logic [7:0] host_period_in,
	// host answers and notices
	output logic host_rsp_valid_out,
	output gpio_pkg::status_t host_rsp_status_out,
	output logic [gpio_pkg::RSP_W-1:0] host_rsp_data_out,
	output logic remote_write_notice_out,
	output logic [2:0] notice_sel_out,
	output logic notice_value_out,
	// link side
	input wire logic link_clk_in,
	input wire logic link_connected_in,
	input wire logic link_valid_in,
	output logic link_ready_out,
	input wire gpio_pkg::cmd_op_t link_op_in,
	input wire logic [2:0] link_sel_in,
	input wire gpio_pkg::pin_func_t link_func_in,
	input wire logic link_value_in,
	input wire logic [7:0] link_ratio_in,
	input wire logic [7:0] link_period_in,
	output logic link_rsp_valid_out,
	output gpio_pkg::status_t link_rsp_status_out,
	output logic [gpio_pkg::RSP_W-1:0] link_rsp_data_out,
	output logic local_write_notice_out,
	output logic [2:0] link_notice_sel_out,
	output logic link_notice_value_out,
	// pins
	input wire logic [gpio_pkg::NUM_PINS-1:0] pin_in,
	output logic [gpio_pkg::NUM_PINS-1:0] pin_out,
	output logic [gpio_pkg::NUM_PINS-1:0] pin_oe_out
);
	import gpio_pkg::*;

	function automatic logic sel_ok(input logic [2:0] sel);
		sel_ok = (sel >= FIRST_SEL) && (sel <= LAST_SEL);
	endfunction

	function automatic logic [2:0] sel_idx(input logic [2:0] sel);
		sel_idx = sel_ok(sel) ? sel - FIRST_SEL : 3'h0;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// link domain: capture, hand over by toggle, return answer and notices

	logic lrst_meta_r, lrstn_r;
	logic lk_busy_r, lk_req_tgl_r;
	cmd_op_t lk_op_r;
	logic [2:0] lk_sel_r;
	pin_func_t lk_func_r;
	logic lk_value_r;
	logic [7:0] lk_ratio_r, lk_period_r;
	logic lk_ack_meta_r, lk_ack_sync_r, lk_ack_seen_r;
	logic lk_nt_meta_r, lk_nt_sync_r, lk_nt_seen_r;
	logic link_take;
	// core domain handover registers, declared here as the link side reads them
	logic ack_tgl_r, nt_tgl_r;
	status_t rem_status_r;
	logic [RSP_W-1:0] rem_data_r;
	logic [2:0] nt_sel_r;
	logic nt_val_r;

	always_ff @(posedge link_clk_in) begin
		lrst_meta_r <= rstn_in;
		lrstn_r <= lrst_meta_r;
	end

	// a link that is not connected cannot hand over any command, setup included
	assign link_ready_out = link_connected_in && !lk_busy_r && lrstn_r;
	assign link_take = link_valid_in && link_ready_out;

	always_ff @(posedge link_clk_in) begin
		if (!lrstn_r) begin
			lk_req_tgl_r <= 1'b0;
			lk_op_r <= OP_READ;
			lk_sel_r <= 3'h0;
			lk_func_r <= FN_NONE;
			lk_value_r <= 1'b0;
			lk_ratio_r <= 8'h00;
			lk_period_r <= 8'h00;
		end else if (link_take) begin
			lk_req_tgl_r <= !lk_req_tgl_r;
			lk_op_r <= link_op_in;
			lk_sel_r <= link_sel_in;
			lk_func_r <= link_func_in;
			lk_value_r <= link_value_in;
			lk_ratio_r <= link_ratio_in;
			lk_period_r <= link_period_in;
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!lrstn_r) begin
			lk_ack_meta_r <= 1'b0;
			lk_ack_sync_r <= 1'b0;
			lk_nt_meta_r <= 1'b0;
			lk_nt_sync_r <= 1'b0;
		end else begin
			lk_ack_meta_r <= ack_tgl_r;
			lk_ack_sync_r <= lk_ack_meta_r;
			lk_nt_meta_r <= nt_tgl_r;
			lk_nt_sync_r <= lk_nt_meta_r;
		end
	end

	// answer words stay still in the core until the next request, so they are safe to copy
	always_ff @(posedge link_clk_in) begin
		if (!lrstn_r) begin
			lk_busy_r <= 1'b0;
			lk_ack_seen_r <= 1'b0;
			link_rsp_valid_out <= 1'b0;
			link_rsp_status_out <= STAT_OK;
			link_rsp_data_out <= '0;
		end else begin
			link_rsp_valid_out <= 1'b0;
			if (link_take) begin
				lk_busy_r <= 1'b1;
			end else if (lk_ack_sync_r != lk_ack_seen_r) begin
				lk_busy_r <= 1'b0;
				lk_ack_seen_r <= lk_ack_sync_r;
				link_rsp_valid_out <= 1'b1;
				link_rsp_status_out <= rem_status_r;
				link_rsp_data_out <= rem_data_r;
			end
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!lrstn_r) begin
			lk_nt_seen_r <= 1'b0;
			local_write_notice_out <= 1'b0;
			link_notice_sel_out <= 3'h0;
			link_notice_value_out <= 1'b0;
		end else begin
			local_write_notice_out <= lk_nt_sync_r != lk_nt_seen_r;
			lk_nt_seen_r <= lk_nt_sync_r;
			if (lk_nt_sync_r != lk_nt_seen_r) begin
				link_notice_sel_out <= nt_sel_r;
				link_notice_value_out <= nt_val_r;
			end
		end
	end

	a_link_busy_after: assert property (@(posedge link_clk_in) disable iff (!lrstn_r)
		link_take |=> !link_ready_out ##1 !link_ready_out)
		else $error("link took a second command while busy");

	////////////////////////////////////////////////////////////////////////////////
	// core domain: synchronisers and command selection

	logic req_meta_r, req_sync_r, req_seen_r;
	logic conn_meta_r, conn_sync_r;
	logic [NUM_PINS-1:0] pin_meta_r, pin_sync_r;
	logic rem_pend, x_fire, x_ok;
	cmd_op_t x_op;
	logic [2:0] x_sel, x_idx;
	pin_func_t x_func;
	logic x_value;
	logic [7:0] x_ratio, x_period;
	logic [RSP_W-1:0] x_data;
	logic [NUM_PINS-1:0] pin_level;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			req_meta_r <= 1'b0;
			req_sync_r <= 1'b0;
			conn_meta_r <= 1'b0;
			conn_sync_r <= 1'b0;
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			req_meta_r <= lk_req_tgl_r;
			req_sync_r <= req_meta_r;
			conn_meta_r <= link_connected_in;
			conn_sync_r <= conn_meta_r;
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// remote commands go first; the host waits at most one cycle per remote command
	assign rem_pend = req_sync_r != req_seen_r;
	assign host_ready_out = !rem_pend;
	assign x_fire = rem_pend || host_valid_in;
	assign x_op = rem_pend ? lk_op_r : host_op_in;
	assign x_sel = rem_pend ? lk_sel_r : host_sel_in;
	assign x_func = rem_pend ? lk_func_r : host_func_in;
	assign x_value = rem_pend ? lk_value_r : host_value_in;
	assign x_ratio = rem_pend ? lk_ratio_r : host_ratio_in;
	assign x_period = rem_pend ? lk_period_r : host_period_in;
	assign x_idx = sel_idx(x_sel);
	assign pin_level = (pin_oe_out & pin_out) | (~pin_oe_out & pin_sync_r);

	////////////////////////////////////////////////////////////////////////////////
	// persistent setup store; cleared only by the defaults command, never by reset

	// power-up contents come from the declarations, so the clocked process stays the only writer
	pin_func_t nv_func [NUM_PINS] = '{default: DEF_FUNC};
	logic [7:0] nv_ratio [NUM_PINS] = '{default: DEF_RATIO};
	logic [7:0] nv_period [NUM_PINS] = '{default: DEF_PERIOD};

	always_comb begin
		x_ok = 1'b0;
		x_data = '0;
		unique case (x_op)
			OP_SETUP: begin
				x_ok = sel_ok(x_sel) && (x_func != FN_PWM || x_sel >= FIRST_PWM_SEL)
					&& (rem_pend || !conn_sync_r);
			end
			OP_READ_SETUP: begin
				x_ok = sel_ok(x_sel);
				x_data[SETUP_FUNC_LSB +: 2] = nv_func[x_idx];
				x_data[SETUP_RATIO_LSB +: 8] = nv_ratio[x_idx];
				x_data[SETUP_PERIOD_LSB +: 8] = nv_period[x_idx];
			end
			OP_WRITE: begin
				x_ok = sel_ok(x_sel) && nv_func[x_idx] == FN_OUTPUT;
			end
			OP_READ: begin
				x_ok = 1'b1;
				x_data[NUM_PINS-1:0] = pin_level;
			end
			OP_DEFAULTS: begin
				x_ok = !rem_pend;
			end
			default: begin
				x_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (x_fire && x_ok && x_op == OP_SETUP) begin
			nv_func[x_idx] <= x_func;
			nv_ratio[x_idx] <= x_ratio;
			nv_period[x_idx] <= x_period;
		end else if (x_fire && x_ok && x_op == OP_DEFAULTS) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				nv_func[i] <= DEF_FUNC;
				nv_ratio[i] <= DEF_RATIO;
				nv_period[i] <= DEF_PERIOD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output levels and answers

	logic [NUM_PINS-1:0] out_val_r;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			out_val_r <= '0;
		end else if (x_fire && x_ok && x_op == OP_WRITE) begin
			out_val_r[x_idx] <= x_value;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			host_rsp_valid_out <= 1'b0;
			host_rsp_status_out <= STAT_OK;
			host_rsp_data_out <= '0;
		end else begin
			host_rsp_valid_out <= x_fire && !rem_pend;
			if (x_fire && !rem_pend) begin
				host_rsp_status_out <= x_ok ? STAT_OK : STAT_REJECT;
				host_rsp_data_out <= x_data;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			req_seen_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			rem_status_r <= STAT_OK;
			rem_data_r <= '0;
		end else if (rem_pend) begin
			req_seen_r <= req_sync_r;
			ack_tgl_r <= !ack_tgl_r;
			rem_status_r <= x_ok ? STAT_OK : STAT_REJECT;
			rem_data_r <= x_data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			nt_tgl_r <= 1'b0;
			nt_sel_r <= 3'h0;
			nt_val_r <= 1'b0;
			remote_write_notice_out <= 1'b0;
			notice_sel_out <= 3'h0;
			notice_value_out <= 1'b0;
		end else begin
			remote_write_notice_out <= x_fire && x_ok && x_op == OP_WRITE && rem_pend;
			if (x_fire && x_ok && x_op == OP_WRITE && rem_pend) begin
				notice_sel_out <= x_sel;
				notice_value_out <= x_value;
			end
			// only a connected peer can take the notice; sel and level hold until the next one
			if (x_fire && x_ok && x_op == OP_WRITE && !rem_pend && conn_sync_r) begin
				nt_tgl_r <= !nt_tgl_r;
				nt_sel_r <= x_sel;
				nt_val_r <= x_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pwm and pin drive

	logic [TICK_W-1:0] tick_cnt_r;
	logic tick_r;
	logic [NUM_PINS-1:0] pwm_w;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= tick_cnt_r == TICK_W'(PWM_TICK_CYCLES - 1);
			tick_cnt_r <= (tick_cnt_r == TICK_W'(PWM_TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
		end
	end

	for (genvar g = 0; g < NUM_PINS; g++) begin : gen_pwm
		if (g >= int'(FIRST_PWM_SEL - FIRST_SEL)) begin : gen_on
			pin_pwm u_pwm (
				.clk_in(clk_in),
				.rstn_in(rstn_in),
				.tick_in(tick_r),
				.ratio_in(nv_ratio[g]),
				.period_in(nv_period[g]),
				.pwm_out(pwm_w[g])
			);
		end else begin : gen_off
			assign pwm_w[g] = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pin_out <= '0;
			pin_oe_out <= '0;
		end else begin
			for (int i = 0; i < NUM_PINS; i++) begin
				pin_oe_out[i] <= nv_func[i] == FN_OUTPUT || nv_func[i] == FN_PWM;
				pin_out[i] <= (nv_func[i] == FN_OUTPUT) ? out_val_r[i]
					: (nv_func[i] == FN_PWM) ? pwm_w[i] : 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_host_take(cmd_op_t op);
		host_valid_in && host_ready_out && host_op_in == op;
	endsequence

	sequence s_host_refused;
		host_rsp_valid_out && host_rsp_status_out == STAT_REJECT;
	endsequence

	a_setup_when_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_host_take(OP_SETUP) and conn_sync_r |=> s_host_refused)
		else $error("host setup taken while connected");
	a_pwm_selector_range: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_host_take(OP_SETUP) and (host_func_in == FN_PWM && host_sel_in < FIRST_PWM_SEL) |=> s_host_refused)
		else $error("pwm setup taken on a plain pin");
	a_unset_write_refused: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_host_take(OP_WRITE) and (nv_func[x_idx] != FN_OUTPUT) |=> s_host_refused)
		else $error("write to a pin not set up as output");
	a_write_reaches_pin: assert property (@(posedge clk_in) disable iff (!rstn_in)
		x_fire && x_ok && x_op == OP_WRITE |=> ##1 pin_out[$past(x_idx, 2)] == $past(x_value, 2))
		else $error("written level missing on pin");
	a_host_answer_once: assert property (@(posedge clk_in) disable iff (!rstn_in)
		host_valid_in && host_ready_out |=> host_rsp_valid_out ##1 (!host_rsp_valid_out || $past(host_valid_in)))
		else $error("host answer missing or repeated");
	a_remote_write_notice: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rem_pend && x_ok && x_op == OP_WRITE |=> remote_write_notice_out && notice_sel_out == $past(x_sel))
		else $error("remote write gave no notice");
	a_local_notice_toggle: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_host_take(OP_WRITE) and x_ok and conn_sync_r |=> nt_tgl_r != $past(nt_tgl_r))
		else $error("host write gave no link notice");
	a_defaults_restored: assert property (@(posedge clk_in) disable iff (!rstn_in)
		s_host_take(OP_DEFAULTS) |=> nv_func[0] == DEF_FUNC && nv_func[NUM_PINS-1] == DEF_FUNC ##1 !pin_oe_out[0])
		else $error("defaults not restored");
	a_remote_one_cycle: assert property (@(posedge clk_in) disable iff (!rstn_in)
		rem_pend |-> !host_ready_out ##1 !rem_pend)
		else $error("remote command held more than one cycle");
endmodule
`default_nettype wire

// *** verification/remote_peer.sv ***
/*
 * Remote peer model: owns the connection flag and issues link commands one at a time.
 * Assumes link_ready of the unit is combinational and settled by the falling link edge.
 */
`timescale 1ns/1ps
`default_nettype none
module remote_peer (
	// link handshake
	input wire logic link_clk_in,
	input wire logic link_ready_in,
	output logic link_connected_out,
	output logic link_valid_out,
	// command fields
	output var gpio_pkg::cmd_op_t link_op_out,
	output logic [2:0] link_sel_out,
	output var gpio_pkg::pin_func_t link_func_out,
	output logic link_value_out,
	output logic [7:0] link_ratio_out,
	output logic [7:0] link_period_out
);
	import gpio_pkg::*;
	initial begin
		link_connected_out = 1'b0;
		link_valid_out = 1'b0;
		link_op_out = OP_READ;
		link_sel_out = 3'h0;
		link_func_out = FN_NONE;
		link_value_out = 1'b0;
		link_ratio_out = 8'h00;
		link_period_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic connect(input logic on);
		@(negedge link_clk_in);
		link_connected_out = on;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// a command is only taken once connected, the unit holds ready low before
	task automatic send(input cmd_op_t op, input logic [2:0] sel, input pin_func_t fn, input logic v,
		input logic [7:0] ra, input logic [7:0] pe, output logic ok);
		int n;
		@(negedge link_clk_in);
		link_op_out = op;
		link_sel_out = sel;
		link_func_out = fn;
		link_value_out = v;
		link_ratio_out = ra;
		link_period_out = pe;
		link_valid_out = 1'b1;
		n = 0;
		while (link_ready_in !== 1'b1 && n < 300) begin
			@(negedge link_clk_in);
			n++;
		end
		ok = (n < 300);
		@(posedge link_clk_in);
		@(negedge link_clk_in);
		link_valid_out = 1'b0;
		// released fields flip so a late sample cannot match by luck
		link_op_out = cmd_op_t'(~link_op_out);
		link_sel_out = ~link_sel_out;
		link_func_out = pin_func_t'(~link_func_out);
		link_value_out = ~link_value_out;
		link_ratio_out = ~link_ratio_out;
		link_period_out = ~link_period_out;
	endtask
endmodule
`default_nettype wire

// *** verification/remote_gpio_pwm_control_test.sv ***
/*
 * Self-checking bench for pin_control: host commands, link commands through remote_peer,
 * notices, pwm waveform and persistence of the pin setup over reset.
 * Assumes the 10 MHz core clock and a free 6 ns link clock.
 */
`timescale 1ns/1ps
`default_nettype none
module remote_gpio_pwm_control_test;
	import gpio_pkg::*;
	typedef struct packed {logic st; logic [RSP_W-1:0] d; logic [RSP_W-1:0] m;} exp_t;
	logic clk_in, link_clk_in, rstn_in, host_valid_in, host_value_in, host_ready_out;
	cmd_op_t host_op_in, link_op_in;
	pin_func_t host_func_in, link_func_in;
	logic [2:0] host_sel_in, link_sel_in, notice_sel_out, link_notice_sel_out;
	logic [7:0] host_ratio_in, host_period_in, link_ratio_in, link_period_in;
	logic host_rsp_valid_out, remote_write_notice_out, notice_value_out, link_connected_in, link_valid_in;
	logic link_ready_out, link_value_in, link_rsp_valid_out, local_write_notice_out, link_notice_value_out, ok;
	status_t host_rsp_status_out, link_rsp_status_out;
	logic [RSP_W-1:0] host_rsp_data_out, link_rsp_data_out;
	logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_out;
	int mismatches, total_checks, cnt, i;
	exp_t hq[$], lq[$], he, le;
	logic [3:0] hnq[$], lnq[$];
	logic [31:0] rng = 32'h00011EF1;
	////////////////////////////////////////////////////////////////////////////////
	pin_control uut (.clk_in(clk_in), .rstn_in(rstn_in), .host_valid_in(host_valid_in),
		.host_ready_out(host_ready_out), .host_op_in(host_op_in), .host_sel_in(host_sel_in),
		.host_func_in(host_func_in), .host_value_in(host_value_in), .host_ratio_in(host_ratio_in),
		.host_period_in(host_period_in), .host_rsp_valid_out(host_rsp_valid_out),
		.host_rsp_status_out(host_rsp_status_out), .host_rsp_data_out(host_rsp_data_out),
		.remote_write_notice_out(remote_write_notice_out), .notice_sel_out(notice_sel_out),
		.notice_value_out(notice_value_out), .link_clk_in(link_clk_in), .link_connected_in(link_connected_in),
		.link_valid_in(link_valid_in), .link_ready_out(link_ready_out), .link_op_in(link_op_in),
		.link_sel_in(link_sel_in), .link_func_in(link_func_in), .link_value_in(link_value_in),
		.link_ratio_in(link_ratio_in), .link_period_in(link_period_in), .link_rsp_valid_out(link_rsp_valid_out),
		.link_rsp_status_out(link_rsp_status_out), .link_rsp_data_out(link_rsp_data_out),
		.local_write_notice_out(local_write_notice_out), .link_notice_sel_out(link_notice_sel_out),
		.link_notice_value_out(link_notice_value_out), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_out(pin_oe_out));
	remote_peer peer (.link_clk_in(link_clk_in), .link_ready_in(link_ready_out),
		.link_connected_out(link_connected_in), .link_valid_out(link_valid_in), .link_op_out(link_op_in),
		.link_sel_out(link_sel_in), .link_func_out(link_func_in), .link_value_out(link_value_in),
		.link_ratio_out(link_ratio_in), .link_period_out(link_period_in));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		link_clk_in = 1'b0;
		#1.7;
		forever #3 link_clk_in = ~link_clk_in;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// every call starts on a falling core edge and returns one idle cycle later
	task automatic hcmd(input cmd_op_t op, input logic [2:0] sel, input pin_func_t fn, input logic v,
		input logic [7:0] ra, input logic [7:0] pe, input logic st, input logic [RSP_W-1:0] d, input logic [RSP_W-1:0] m);
		int n;
		hq.push_back('{st, d, m});
		host_op_in = op;
		host_sel_in = sel;
		host_func_in = fn;
		host_value_in = v;
		host_ratio_in = ra;
		host_period_in = pe;
		host_valid_in = 1'b1;
		n = 0;
		while (host_ready_out !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		@(negedge clk_in);
		host_valid_in = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic rcmd(input cmd_op_t op, input logic [2:0] sel, input pin_func_t fn, input logic v,
		input logic [7:0] ra, input logic [7:0] pe, input logic st, input logic [RSP_W-1:0] d, input logic [RSP_W-1:0] m);
		int n;
		lq.push_back('{st, d, m});
		peer.send(op, sel, fn, v, ra, pe, ok);
		chk(32'(ok), 32'h1);
		n = 0;
		while (lq.size() != 0 && n < 400) begin
			@(negedge link_clk_in);
			n++;
		end
		@(negedge clk_in);
	endtask
	task automatic rst();
		rstn_in = 1'b0;
		repeat (5) @(negedge clk_in);
		rstn_in = 1'b1;
		@(negedge clk_in);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge clk_in) begin
		if (host_rsp_valid_out === 1'b1) begin
			he = (hq.size() != 0) ? hq.pop_front() : exp_t'{1'b1, '1, '1};
			chk(32'(host_rsp_status_out), 32'(he.st));
			chk(32'(host_rsp_data_out & he.m), 32'(he.d & he.m));
		end
		if (remote_write_notice_out === 1'b1)
			chk(32'({notice_sel_out, notice_value_out}), 32'((hnq.size() != 0) ? hnq.pop_front() : 4'hF));
	end
	always @(negedge link_clk_in) begin
		if (link_rsp_valid_out === 1'b1) begin
			le = (lq.size() != 0) ? lq.pop_front() : exp_t'{1'b1, '1, '1};
			chk(32'(link_rsp_status_out), 32'(le.st));
			chk(32'(link_rsp_data_out & le.m), 32'(le.d & le.m));
		end
		if (local_write_notice_out === 1'b1)
			chk(32'({link_notice_sel_out, link_notice_value_out}), 32'((lnq.size() != 0) ? lnq.pop_front() : 4'hF));
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		chk(32'(hq.size() + lq.size() + hnq.size() + lnq.size()), 32'h0);
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		{host_valid_in, host_value_in, host_sel_in, host_ratio_in, host_period_in} = '0;
		host_op_in = OP_READ;
		host_func_in = FN_NONE;
		pin_in = NUM_PINS'(xs());
		rst();
		for (i = 1; i <= 6; i++)
			hcmd(OP_READ_SETUP, 3'(i), FN_NONE, 0, 0, 0, STAT_OK, {DEF_FUNC, DEF_RATIO, DEF_PERIOD}, '1);
		$display("test power-up setup done");
		hcmd(OP_SETUP, 1, FN_OUTPUT, 0, 0, 0, STAT_OK, 0, '1);
		hcmd(OP_SETUP, 2, FN_INPUT, 0, 0, 0, STAT_OK, 0, '1);
		hcmd(OP_SETUP, 2, FN_PWM, 0, 8'h40, 8'h04, STAT_REJECT, 0, '1);
		hcmd(OP_SETUP, 0, FN_OUTPUT, 0, 0, 0, STAT_REJECT, 0, '1);
		hcmd(OP_SETUP, 7, FN_INPUT, 0, 0, 0, STAT_REJECT, 0, '1);
		hcmd(cmd_op_t'(3'h5), 1, FN_NONE, 0, 0, 0, STAT_REJECT, 0, '1);
		for (i = 3; i <= 6; i++)
			hcmd(OP_SETUP, 3'(i), FN_PWM, 0, 8'h40, 8'h04, STAT_OK, 0, '1);
		for (i = 4; i <= 6; i++)
			hcmd(OP_SETUP, 3'(i), FN_INPUT, 0, 0, 0, STAT_OK, 0, '1);
		hcmd(OP_WRITE, 2, FN_NONE, 1, 0, 0, STAT_REJECT, 0, '1);
		hcmd(OP_WRITE, 3, FN_NONE, 1, 0, 0, STAT_REJECT, 0, '1);
		$display("test setup done");
		hcmd(OP_WRITE, 1, FN_NONE, 1, 0, 0, STAT_OK, 0, '1);
		@(negedge clk_in);
		chk(32'({pin_out[0], pin_oe_out[0]}), 32'h3);
		pin_in = NUM_PINS'(xs());
		repeat (4) @(negedge clk_in);
		hcmd(OP_READ, 1, FN_NONE, 0, 0, 0, STAT_OK, {pin_in[5:1], 1'b1}, 18'h3FFFB);
		cnt = 0;
		repeat (2 * 4 * PWM_TICK_CYCLES) begin
			@(negedge clk_in);
			cnt += pin_out[2];
		end
		chk(cnt, 2 * (8'h40 * 4 / 256) * PWM_TICK_CYCLES);
		$display("test write read pwm done");
		peer.connect(1);
		repeat (4) @(negedge clk_in);
		hcmd(OP_SETUP, 1, FN_INPUT, 0, 0, 0, STAT_REJECT, 0, '1);
		hnq.push_back({3'h1, 1'b0});
		rcmd(OP_WRITE, 1, FN_NONE, 0, 0, 0, STAT_OK, 0, '1);
		@(negedge clk_in);
		chk(32'(pin_out[0]), 32'h0);
		rcmd(OP_READ_SETUP, 3, FN_NONE, 0, 0, 0, STAT_OK, {FN_PWM, 8'h40, 8'h04}, '1);
		rcmd(OP_SETUP, 4, FN_OUTPUT, 0, 0, 0, STAT_OK, 0, '1);
		hnq.push_back({3'h4, 1'b1});
		rcmd(OP_WRITE, 4, FN_NONE, 1, 0, 0, STAT_OK, 0, '1);
		rcmd(OP_READ, 1, FN_NONE, 0, 0, 0, STAT_OK, {pin_in[5:4], 1'b1, 1'b0, pin_in[1], 1'b0}, 18'h3FFFB);
		rcmd(OP_DEFAULTS, 1, FN_NONE, 0, 0, 0, STAT_REJECT, 0, '1);
		lnq.push_back({3'h1, 1'b1});
		hcmd(OP_WRITE, 1, FN_NONE, 1, 0, 0, STAT_OK, 0, '1);
		repeat (20) @(negedge clk_in);
		$display("test link done");
		peer.connect(0);
		repeat (4) @(negedge clk_in);
		chk(32'(link_ready_out), 32'h0);
		rst();
		hcmd(OP_READ_SETUP, 3, FN_NONE, 0, 0, 0, STAT_OK, {FN_PWM, 8'h40, 8'h04}, '1);
		hcmd(OP_DEFAULTS, 1, FN_NONE, 0, 0, 0, STAT_OK, 0, '1);
		hcmd(OP_READ_SETUP, 3, FN_NONE, 0, 0, 0, STAT_OK, {DEF_FUNC, DEF_RATIO, DEF_PERIOD}, '1);
		$display("test persistence done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
